//--- testbench/eeprom_write_all_cycle_start_bench.sv
// bench for the program-all control block driven by a host model
// assumes a 50 MHz clock and a program time shortened to 2000 cycles
`timescale 1ns/1ps
module eeprom_write_all_cycle_start_bench;
	localparam int PC = 2000;
	logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, supply_ok_i = 1'b1;
	logic [9:0] peek_addr_i = 10'h0;
	logic [15:0] peek_data_o;
	logic sel, sck, sdat, data_out_o, data_out_oe_o, unlocked_o, busy_o;
	int fail_count = 0, n_compared = 0, cycles = 0;
	initial forever #10 ref_clk_i = ~ref_clk_i;
	host_model i_host (.ref_clk_i(ref_clk_i), .sel_o(sel), .sck_o(sck), .sdat_o(sdat));
	prog_all_ctl #(.PROG_CYCLES(PC)) i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.supply_ok_i(supply_ok_i), .chip_select_i(sel), .serial_clock_in_i(sck),
		.serial_data_in_i(sdat), .data_out_o(data_out_o), .data_out_oe_o(data_out_oe_o),
		.unlocked_o(unlocked_o), .busy_o(busy_o), .peek_addr_i(peek_addr_i),
		.peek_data_o(peek_data_o));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge ref_clk_i) if (++cycles > 30000) begin
		fail_count++;
		results();
	end
	// frame cut to its first n bits; late adds a rise after the last bit
	task automatic t_frame(input logic [15:0] w, input int n, input bit late, input logic exp);
		i_host.send({5'h11, 8'h00, w} >> (29 - n), n, late);
		check(16'(busy_o), 16'(exp));
	endtask
	task automatic t_done(input logic [15:0] w, input bit poll);
		if (poll) begin
			i_host.select(1'b1);
			repeat (8) @(posedge ref_clk_i);
			check(16'({data_out_oe_o, data_out_o}), 16'h2);
			i_host.send(29'h1000, 13, 1'b0); // lock attempt mid-program
		end
		for (int k = 0; k < PC + 50 && busy_o !== 1'b0; k++) @(posedge ref_clk_i);
		repeat (3) @(posedge ref_clk_i);
		check(16'({unlocked_o, data_out_o}), 16'h3);
		for (int a = 0; a < 1024; a += 341) begin
			peek_addr_i <= 10'(a);
			repeat (2) @(posedge ref_clk_i);
			check(peek_data_o, w);
		end
	endtask
	initial begin
		repeat (20) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		t_frame(16'h1234, 29, 1'b0, 1'b0);
		i_host.send(29'h1300, 13, 1'b0);
		check(16'(unlocked_o), 16'h1);
		t_frame(16'ha5c3, 29, 1'b0, 1'b1);
		t_done(16'ha5c3, 1'b1);
		t_frame(16'h5a3c, 29, 1'b0, 1'b1);
		t_done(16'h5a3c, 1'b0);
		t_frame(16'h0f0f, 29, 1'b1, 1'b0);
		t_frame(16'h0f0f, 20, 1'b0, 1'b0);
		t_done(16'h5a3c, 1'b0);
		supply_ok_i <= 1'b0;
		repeat (6) @(posedge ref_clk_i);
		supply_ok_i <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		check(16'(unlocked_o), 16'h0);
		t_frame(16'hffff, 29, 1'b0, 1'b0);
		results();
	end
endmodule // eeprom_write_all_cycle_start_bench
bind prog_all_ctl prog_all_ctl_assertions #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
	.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .supply_ok_i(supply_ok_i),
	.chip_select_i(chip_select_i), .data_out_o(data_out_o), .data_out_oe_o(data_out_oe_o),
	.unlocked_o(unlocked_o), .busy_o(busy_o));

//--- testbench/host_model.sv
// host side of the serial link: select, serial clock and data
// assumes ref_clk_i paces the 160 ns serial clock, 8 cycles a bit
`timescale 1ns/1ps
module host_model (
	// pacing clock
	input wire logic ref_clk_i,
	// serial pins towards the device
	output logic sel_o,
	output logic sck_o,
	output logic sdat_o
);
	initial {sel_o, sck_o, sdat_o} = 3'h0;
	task automatic select(input logic v);
		@(posedge ref_clk_i);
		sel_o <= v;
	endtask
	task automatic pulse;
		repeat (4) @(posedge ref_clk_i);
		sck_o <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		sck_o <= 1'b0;
	endtask
	// start bit, opcode, address, data, msb first
	task automatic send(input logic [28:0] bits, input int n, input bit late);
		select(1'b1);
		for (int i = n - 1; i >= 0; i--) begin
			sdat_o <= bits[i];
			pulse();
		end
		if (late) pulse(); // extra rise misses the start window
		select(1'b0); // dropped before the next rise
		sdat_o <= ~sdat_o; // released line keeps no stale level
		repeat (14) @(posedge ref_clk_i); // select low beyond 250 ns
	endtask
endmodule // host_model

//--- testbench/prog_all_ctl_assertions.sv
// pin-level assertions for the program-all control block
// assumes binding to prog_all_ctl; one clock, sync reset
`timescale 1ns/1ps
module prog_all_ctl_assertions #(parameter int PROG_CYCLES = 2000) (
	// watched ports
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic supply_ok_i,
	input wire logic chip_select_i,
	input wire logic data_out_o,
	input wire logic data_out_oe_o,
	input wire logic unlocked_o,
	input wire logic busy_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	// busy length too long for a repetition, so counted
	logic [31:0] busy_cnt_reg;
	always_ff @(posedge ref_clk_i) busy_cnt_reg <= busy_o ? busy_cnt_reg + 32'h1 : 32'h0;
	a_start_unlocked: assert property ($rose(busy_o) |-> unlocked_o)
		else $error("start while locked");
	a_start_deselected: assert property ($rose(busy_o) |-> !chip_select_i)
		else $error("start while selected");
	a_busy_length: assert property ($fell(busy_o) && supply_ok_i |->
		busy_cnt_reg >= PROG_CYCLES && busy_cnt_reg <= PROG_CYCLES + 4)
		else $error("busy length wrong");
	a_busy_status_low: assert property (data_out_oe_o |-> !data_out_o)
		else $error("status high while busy");
	a_ready_after: assert property ($fell(busy_o) |-> ##[0:2] data_out_o)
		else $error("no ready after busy");
	a_status_driven: assert property ((busy_o && chip_select_i) [*6] |-> data_out_oe_o)
		else $error("status not driven");
	a_no_drive_idle: assert property (!chip_select_i [*6] |-> !data_out_oe_o)
		else $error("driven while deselected");
	a_power_reset: assert property (!supply_ok_i [*5] |-> !unlocked_o && !busy_o)
		else $error("not reset at low supply");
	a_lock_held_busy: assert property (busy_o && $past(busy_o) |-> $stable(unlocked_o))
		else $error("lock changed while busy");
	c_start: cover property ($rose(busy_o));
	c_poll: cover property (data_out_oe_o);
	c_relock: cover property ($fell(unlocked_o));
endmodule // prog_all_ctl_assertions

//--- verilog/prog_all_ctl.sv
// serial control for program-all, unlock and lock with ready/busy polling
// assumes host pins are asynchronous and sampled by ref_clk_i
`timescale 1ns/1ps
`include "prog_all_params.svh"
module prog_all_ctl #(
	parameter int PROG_CYCLES = `PROG_CYCLES,
	parameter int AW = `ADDR_BITS,
	parameter int DW = `DATA_BITS
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// supply monitor, high while supply above threshold
	input wire logic supply_ok_i,
	// host serial pins
	input wire logic chip_select_i,
	input wire logic serial_clock_in_i,
	input wire logic serial_data_in_i,
	output logic data_out_o,
	output logic data_out_oe_o,
	// status
	output logic unlocked_o,
	output logic busy_o,
	// memory peek
	input wire logic [AW-1:0] peek_addr_i,
	output logic [DW-1:0] peek_data_o
);
	localparam int FRAME_BITS = `HDR_BITS + AW + DW;
	localparam int CNT_W = $clog2(PROG_CYCLES + 1);
	localparam int BIT_W = $clog2(FRAME_BITS + 1);

	logic [2:0] cs_sync_reg;
	logic [2:0] sk_sync_reg;
	logic [1:0] di_sync_reg;
	logic [2:0] sup_sync_reg;
	prog_all_pkg::pin_evt_s evt;
	prog_all_pkg::ctl_state_e state_reg, state_next;
	logic [BIT_W-1:0] bit_cnt_reg;
	logic [FRAME_BITS-1:0] shift_reg;
	logic [DW-1:0] word_reg;
	logic unlocked_reg;
	logic [CNT_W-1:0] timer_reg;
	logic [AW-1:0] waddr_reg;
	logic we_reg;
	logic rst;

	// metastability guard; only stage 1 and later are read
	always_ff @(posedge ref_clk_i) begin
		cs_sync_reg <= {cs_sync_reg[1:0], chip_select_i};
		sk_sync_reg <= {sk_sync_reg[1:0], serial_clock_in_i};
		di_sync_reg <= {di_sync_reg[0], serial_data_in_i};
		sup_sync_reg <= {sup_sync_reg[1:0], supply_ok_i};
	end

	// supply low holds all control and status registers in reset; the word store keeps its contents
	assign rst = sys_rst_i | ~sup_sync_reg[1]; // see R9
	assign evt.sel = cs_sync_reg[1];
	assign evt.clk_rise = sk_sync_reg[1] & ~sk_sync_reg[2];
	assign evt.clk_fall = ~sk_sync_reg[1] & sk_sync_reg[2];
	assign evt.data = di_sync_reg[1];
	wire sel_fall = ~cs_sync_reg[1] & cs_sync_reg[2];

	// short frames end at the address, so their header sits lower in the shifter
	function automatic logic [3:0] hdr_fields(input logic [FRAME_BITS-1:0] sr, input logic full);
		logic [3:0] f;
		if (full) begin
			f = sr[AW+DW+1:AW+DW-2];
		end else begin
			f = sr[AW+1:AW-2];
		end
		return f;
	endfunction

	// frame layout: start, opcode, address, data, msb first
	wire [3:0] hdr_short = hdr_fields(shift_reg, 1'b0); // see R10
	wire [3:0] hdr_full = hdr_fields(shift_reg, 1'b1); // see R10
	wire [1:0] opc = hdr_full[3:2];
	wire [1:0] pfx = hdr_full[1:0];
	wire [1:0] pfx_short = hdr_short[1:0];
	wire special = opc == `OPC_SPECIAL;
	wire special_short = hdr_short[3:2] == `OPC_SPECIAL;
	// prefix only valid once the whole address field is in
	wire short_done = (bit_cnt_reg == BIT_W'(`HDR_BITS + AW)) && special_short &&
		(pfx_short != `PFX_ALL);
	wire full_done = bit_cnt_reg == BIT_W'(FRAME_BITS);
	wire is_all = special && (pfx == `PFX_ALL);
	wire last_word = waddr_reg == {AW{1'b1}};
	wire timer_zero = timer_reg == '0;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			prog_all_pkg::ST_IDLE: begin
				if (evt.sel && evt.clk_rise && evt.data) begin
					state_next = prog_all_pkg::ST_SHIFT;
				end
			end
			prog_all_pkg::ST_SHIFT: begin
				if (!evt.sel) begin
					state_next = prog_all_pkg::ST_IDLE;
				end else if (full_done && is_all) begin
					state_next = prog_all_pkg::ST_ARMED;
				end else if (full_done || short_done) begin
					state_next = prog_all_pkg::ST_DONE;
				end
			end
			prog_all_pkg::ST_ARMED: begin
				// window is one serial clock period after the last bit
				if (sel_fall && unlocked_reg) begin
					state_next = prog_all_pkg::ST_PROG; // see R1, R12
				end else if (sel_fall || evt.clk_rise) begin
					state_next = prog_all_pkg::ST_DONE; // see R7
				end
			end
			prog_all_pkg::ST_PROG: begin
				// self timed, serial clock ignored
				if (timer_zero && last_word) begin
					state_next = prog_all_pkg::ST_IDLE; // see R3, R13
				end
			end
			prog_all_pkg::ST_DONE: begin
				if (!evt.sel) begin
					state_next = prog_all_pkg::ST_IDLE;
				end
			end
			default: state_next = prog_all_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst) begin
			state_reg <= prog_all_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// locked from power-up; unlock and lock take effect at frame end
	always_ff @(posedge ref_clk_i) begin
		if (rst) begin
			unlocked_reg <= 1'b0; // see R8
		end else if (state_reg == prog_all_pkg::ST_SHIFT && short_done && evt.sel) begin
			if (pfx_short == `PFX_UNLOCK) begin
				unlocked_reg <= 1'b1; // see R12
			end else if (pfx_short == `PFX_LOCK) begin
				unlocked_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst || state_reg == prog_all_pkg::ST_IDLE) begin
			bit_cnt_reg <= BIT_W'(1);
			shift_reg <= '0;
		end else if (state_reg == prog_all_pkg::ST_SHIFT && evt.clk_rise) begin
			bit_cnt_reg <= bit_cnt_reg + BIT_W'(1);
			shift_reg <= {shift_reg[FRAME_BITS-2:0], evt.data};
		end
	end

	// timer stretches the whole cycle to the pulse width
	// reloaded every armed cycle so a stale count never leaks into a new cycle
	always_ff @(posedge ref_clk_i) begin
		if (rst) begin
			timer_reg <= '0;
		end else if (state_reg == prog_all_pkg::ST_ARMED) begin
			timer_reg <= CNT_W'(PROG_CYCLES);
		end else if (state_reg == prog_all_pkg::ST_PROG && !timer_zero) begin
			timer_reg <= timer_reg - CNT_W'(1);
		end
	end

	// write one word per step
	always_ff @(posedge ref_clk_i) begin
		if (rst) begin
			word_reg <= `ERASED_WORD;
			waddr_reg <= '0;
			we_reg <= 1'b0;
		end else if (state_reg == prog_all_pkg::ST_ARMED) begin
			word_reg <= shift_reg[DW-1:0];
			waddr_reg <= '0;
			we_reg <= 1'b0;
		end else if (state_reg == prog_all_pkg::ST_PROG) begin
			we_reg <= 1'b1; // see R1, R5
			if (we_reg && !last_word) begin
				waddr_reg <= waddr_reg + AW'(1);
			end
			if (timer_zero && last_word) begin
				we_reg <= 1'b0;
			end
		end else begin
			we_reg <= 1'b0;
		end
	end

	// status on data-out while selected during a program cycle
	always_ff @(posedge ref_clk_i) begin
		if (rst) begin
			data_out_o <= 1'b1;
			data_out_oe_o <= 1'b0;
			busy_o <= 1'b0;
			unlocked_o <= 1'b0;
		end else begin
			busy_o <= state_reg == prog_all_pkg::ST_PROG;
			unlocked_o <= unlocked_reg;
			data_out_o <= state_reg != prog_all_pkg::ST_PROG; // see R11
			data_out_oe_o <= evt.sel && (state_reg == prog_all_pkg::ST_PROG); // see R4
		end
	end

	word_store #(
		.AW(AW),
		.DW(DW)
	) u_store (
		.clk_i(ref_clk_i),
		.we_i(we_reg && state_reg == prog_all_pkg::ST_PROG),
		.waddr_i(waddr_reg),
		.wdata_i(word_reg),
		.raddr_i(peek_addr_i),
		.rdata_o(peek_data_o)
	);
endmodule // prog_all_ctl

//--- verilog/prog_all_params.svh
// constants and timing counts for the program-all control block
// assumes a 50 MHz system clock sampling the host serial pins
// Function
// R1 - complete program-all frame starts self-timed program of every location on select fall
// R2 - host keeps select low at least the minimum select low time
// R3 - program cycle finishes without any serial clock edges
// R4 - host may reselect during program and read ready/busy on data-out
// R5 - each word is stored correctly without a prior clear
// R6 - host drops select before next rising clock after last data bit
// R7 - select fall outside the one-period window starts no cycle
// R8 - power-up leaves device locked: reads work, program commands refused
// R9 - logic held in reset while supply is below power-on threshold
// R10 - frame is start bit, two-bit opcode, address field, then data
// R11 - data-out low while busy, high once ready
// R12 - program commands need unlock since power-up or last lock
// R13 - during a program cycle new instruction bits are ignored
`ifndef PROG_ALL_PARAMS_SVH
`define PROG_ALL_PARAMS_SVH
`define CLK_PERIOD_NS 20
`define PROG_TIME_US 5000
`define PROG_CYCLES ((`PROG_TIME_US * 1000) / `CLK_PERIOD_NS)
`define MIN_SEL_LOW_NS 250
`define MIN_SEL_LOW_CYCLES ((`MIN_SEL_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_BITS 10
`define DATA_BITS 16
`define HDR_BITS 3
`define OPC_SPECIAL 2'h0
`define PFX_UNLOCK 2'h3
`define PFX_LOCK 2'h0
`define PFX_ALL 2'h1
`define ERASED_WORD 16'hffff
`endif

//--- verilog/prog_all_pkg.sv
// types for the program-all control block
// assumes prog_all_params.svh is included by the users of these types
package prog_all_pkg;
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SHIFT = 5'h02,
		ST_ARMED = 5'h04,
		ST_PROG = 5'h08,
		ST_DONE = 5'h10
	} ctl_state_e;
	typedef struct packed {
		logic sel;
		logic clk_rise;
		logic clk_fall;
		logic data;
	} pin_evt_s;
endpackage

//--- verilog/word_store.sv
// word memory with registered read port and a single-word write port
// assumes one clock; write-all takes one cycle per word
`timescale 1ns/1ps
module word_store #(
	parameter int AW = 10,
	parameter int DW = 16
) (
	// clock
	input wire logic clk_i,
	// write port
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	// read port
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i; // see R5
		end
		rdata_o <= mem[raddr_i];
	end
endmodule // word_store
